// ===== src/pft_pkg.sv
// Constants, register layout and carrier types for the flash table access.
// Assumes one core clock domain shared by the core, the SFR bus and the
// flash array macro.
package pft_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses and fields
  localparam logic [15:0] ADDR_CTRL = 16'h0760; // flash_op_control
  localparam logic [15:0] ADDR_KEY  = 16'h0766; // flash_unlock_key
  localparam int BIT_WR    = 15;
  localparam int BIT_FLASH_WRITE_ENABLE  = 14;
  localparam int BIT_FLASH_WRITE_ERROR = 13;
  localparam int BIT_ERASE = 6;
  localparam int OP_LSB    = 0;
  localparam int OP_W      = 4;
  localparam logic [15:0] CTRL_RST = 16'h0000;  // Power-on value only
  localparam logic [7:0]  KEY_RST  = 8'h00;

  // Operation codes and unlock sequence
  localparam logic [3:0] OP_ROW  = 4'h1;
  localparam logic [3:0] OP_PAGE = 4'h2;
  localparam logic [3:0] OP_WORD = 4'h3;
  localparam logic [7:0] KEY1    = 8'h55;
  localparam logic [7:0] KEY2    = 8'hAA;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int PC_W       = 24;
  localparam int PAGE_W     = 8;
  localparam int EA_W       = 16;
  localparam int ROW_INSTR  = 64;    // 192 bytes
  localparam int PAGE_INSTR = 512;   // 1536 bytes
  localparam int ROW_LSB    = $clog2(2 * ROW_INSTR);   // Address units
  localparam int PAGE_LSB   = $clog2(2 * PAGE_INSTR);

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic            valid;
    logic            write;
    logic            high;       // High word, bits 23:16
    logic            byte_mode;
    logic [EA_W-1:0] ea;
    logic [15:0]     wdata;
  } pft_tbl_req_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pft_sfr_req_s;

  typedef struct packed {
    logic            rd;
    logic            prog;
    logic            erase;
    logic [PC_W-1:0] addr;
    logic [PC_W-1:0] data;
  } pft_fl_cmd_s;

endpackage

// ===== src/pft_addr_fmt.sv
// Address former and lane steering for table reads and writes.
// Purely combinational; the caller registers whatever it drives out.
`timescale 1ns/1ps
module pft_addr_fmt (
  input  wire logic [pft_pkg::PAGE_W-1:0] i_page,    // Table page
  input  wire pft_pkg::pft_tbl_req_s      i_req,     // Table request
  input  wire logic [pft_pkg::PC_W-1:0]   i_old,     // Current latch word
  input  wire logic [pft_pkg::PC_W-1:0]   i_fl_word, // Flash read word
  output logic      [pft_pkg::PC_W-1:0]   o_addr,    // Program address
  output logic      [pft_pkg::PC_W-1:0]   o_merged,  // Latch after write
  output logic      [15:0]                o_rdata    // Read lane
);

  // Page bits on top, effective address below
  assign o_addr = {i_page, i_req.ea};

  ////////////////////////////////////////////////////////////////////////////
  // Write merge: byte mode picks a lane by the address LSB
  always_comb begin
    o_merged = i_old;
    if (!i_req.high) begin
      if (!i_req.byte_mode) begin
        o_merged[15:0] = i_req.wdata;
      end else if (i_req.ea[0]) begin
        o_merged[15:8] = i_req.wdata[7:0];
      end else begin
        o_merged[7:0] = i_req.wdata[7:0];
      end
    end else if (!i_req.byte_mode || !i_req.ea[0]) begin
      o_merged[23:16] = i_req.wdata[7:0];
    end
  end

  // Read lane; the upper byte of the high word does not exist, reads zero
  always_comb begin
    o_rdata = 16'h0000;
    if (!i_req.high) begin
      if (!i_req.byte_mode) begin
        o_rdata = i_fl_word[15:0];
      end else if (i_req.ea[0]) begin
        o_rdata = {8'h00, i_fl_word[15:8]};
      end else begin
        o_rdata = {8'h00, i_fl_word[7:0]};
      end
    end else if (!i_req.byte_mode || !i_req.ea[0]) begin
      o_rdata = {8'h00, i_fl_word[23:16]};
    end
  end

endmodule

// ===== src/pft_op_seq.sv
// Program/erase sequencer: issues one flash command per word and waits for
// the macro's done. Assumes done and err are same-clock, one-cycle pulses.
`timescale 1ns/1ps
module pft_op_seq #(
  parameter int MAX_WORDS = 64  // Longest burst, one row
) (
  input  wire logic                         i_core_clk, // Core clock
  input  wire logic                         i_nrst,     // Async reset, low
  input  wire logic                         i_ce,       // Clock enable
  input  wire logic                         i_abort,    // Drop operation
  input  wire logic                         i_start,    // Begin burst
  input  wire logic [$clog2(MAX_WORDS):0]   i_count,    // Words in burst
  input  wire logic                         i_fl_done,  // Command finished
  input  wire logic                         i_fl_err,   // Command failed
  output logic                              o_issue,    // Send command now
  output logic      [$clog2(MAX_WORDS)-1:0] o_idx,      // Word index
  output logic                              o_busy,     // Burst running
  output logic                              o_fin,      // Burst done
  output logic                              o_fail      // Burst failed
);

  localparam int IW = $clog2(MAX_WORDS);

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} pft_seq_e;
  pft_seq_e      state_r;
  logic [IW-1:0] idx_r;
  logic [IW:0]   last_r;

  if (MAX_WORDS < 2) begin : g_bad_words
    $error("MAX_WORDS must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst walk; abort wins over everything so a reset never half-finishes
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= S_IDLE;
      idx_r   <= '0;
      last_r  <= '0;
    end else if (i_ce) begin
      case (state_r)
        S_IDLE: begin
          if (i_start && !i_abort) begin
            state_r <= S_ISSUE;
            idx_r   <= '0;
            last_r  <= i_count - 1'b1;
          end
        end
        S_ISSUE: begin
          state_r <= i_abort ? S_IDLE : S_WAIT;
        end
        S_WAIT: begin
          if (i_abort || i_fl_err) begin
            state_r <= S_IDLE;
          end else if (i_fl_done) begin
            if ({1'b0, idx_r} == last_r) begin
              state_r <= S_IDLE;
            end else begin
              state_r <= S_ISSUE;
              idx_r   <= idx_r + 1'b1;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  assign o_issue = (state_r == S_ISSUE) && !i_abort;
  assign o_idx   = idx_r;
  assign o_busy  = (state_r != S_IDLE);
  assign o_fin   = i_ce && (state_r == S_WAIT) && !i_abort && !i_fl_err
                   && i_fl_done && ({1'b0, idx_r} == last_r);
  assign o_fail  = i_ce && (state_r == S_WAIT) && !i_abort && i_fl_err;

endmodule

// ===== src/pft_table_access.sv
// Top of the run-time flash access path: table read/write port, write
// latch, control and key registers, and the flash macro command port.
// Assumes core, SFR bus and flash macro share i_core_clk.
//
// Contract
// - Flash reads, writes, erases work in normal operation, no special mode.
// - All programming passes through the table read/write path.
// - Table accesses reach program memory while in normal mode.
// - Program address is table page bits 7:0 joined to the effective address.
// - Low-word table accesses move bits 15:0, word or byte size.
// - High-word table accesses move bits 23:16, word or byte size.
// - Programming writes a 64-instruction row or a single instruction.
// - Erase clears one 512-instruction page.
// - Control at 0760: start 15, enable 14, error 13, erase 6, op 3:0.
// - Control resets to 0000 on power-on; other resets depend on activity.
`timescale 1ns/1ps
module pft_table_access #(
  parameter int ROW_WORDS = pft_pkg::ROW_INSTR  // Write latch depth
) (
  input  wire logic                         i_core_clk,       // Core clock
  input  wire logic                         i_nrst,           // Power-on rst
  input  wire logic                         i_ce,             // Clock enable
  input  wire logic                         i_sys_rst,        // Other reset
  input  wire logic [pft_pkg::PAGE_W-1:0]   i_table_page_reg, // Table page
  input  wire pft_pkg::pft_tbl_req_s        i_tbl,            // Table request
  input  wire pft_pkg::pft_sfr_req_s        i_sfr,            // SFR access
  input  wire logic                         i_fl_done,        // Macro done
  input  wire logic                         i_fl_err,         // Macro fault
  input  wire logic [pft_pkg::PC_W-1:0]     i_fl_rdata,       // Macro data
  output logic                              o_tbl_ack,        // Table ack
  output logic      [15:0]                  o_tbl_rdata,      // Table data
  output logic      [15:0]                  o_sfr_rdata,      // SFR data
  output pft_pkg::pft_fl_cmd_s              o_fl_cmd,         // Macro cmd
  output logic                              o_busy            // Op running
);

  localparam int IW = $clog2(ROW_WORDS);

  if (ROW_WORDS != pft_pkg::ROW_INSTR) begin : g_bad_row
    $error("ROW_WORDS must be 64");
  end

  typedef enum logic [1:0] {T_IDLE, T_RD, T_GAP} pft_tbl_e;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  pft_tbl_e                    tstate_r;
  pft_pkg::pft_tbl_req_s       req_r;
  logic [pft_pkg::PC_W-1:0]    latch_mem [ROW_WORDS];
  logic [pft_pkg::PC_W-1:0]    addr_r;
  logic                        wr_r, flash_write_enable_r, flash_write_error_r, erase_r;
  logic [3:0]                  op_r;
  logic [7:0]                  key_r;
  logic [1:0]                  unlock_r;
  logic [pft_pkg::PC_W-1:0]    fmt_addr, fmt_merged;
  logic [15:0]                 fmt_rdata;
  logic                        seq_issue, seq_busy, seq_fin, seq_fail;
  logic [IW-1:0]               seq_idx;
  logic [IW:0]                 seq_count;
  logic                        ctrl_wr, key_wr, start_req, op_ok, go;
  logic                        rd_take, wt_take, abort;
  logic [15:0]                 ctrl_val;
  logic [IW-1:0]               wr_idx;

  assign wr_idx   = i_tbl.ea[IW:1];
  assign ctrl_wr  = i_sfr.wr && (i_sfr.addr == pft_pkg::ADDR_CTRL);
  assign key_wr   = i_sfr.wr && (i_sfr.addr == pft_pkg::ADDR_KEY);
  assign ctrl_val = {wr_r, flash_write_enable_r, flash_write_error_r, 6'h00, erase_r, 2'h0, op_r};
  assign abort    = i_sys_rst && seq_busy;

  // Only these erase/op pairs name a real operation
  assign op_ok = (!erase_r && (op_r == pft_pkg::OP_ROW))
               || (!erase_r && (op_r == pft_pkg::OP_WORD))
               || (erase_r && (op_r == pft_pkg::OP_PAGE));

  // Start needs enable already set and the unlock sequence just done
  assign start_req = ctrl_wr && i_sfr.wdata[pft_pkg::BIT_WR] && !wr_r
                     && flash_write_enable_r && (unlock_r == 2'd2) && !i_sys_rst;
  assign go = start_req && op_ok && (tstate_r == T_IDLE);

  // Table traffic waits while an operation owns the flash macro or starts
  // this cycle; a read and a start together would overlap two commands
  assign rd_take = i_tbl.valid && !i_tbl.write && (tstate_r == T_IDLE)
                   && !seq_busy && !wr_r && !i_sys_rst && !go;
  assign wt_take = i_tbl.valid && i_tbl.write && (tstate_r == T_IDLE)
                   && !seq_busy && !wr_r && !i_sys_rst && !go;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  pft_addr_fmt u_fmt (
    .i_page    (i_table_page_reg),
    .i_req     ((tstate_r == T_RD) ? req_r : i_tbl),
    .i_old     (latch_mem[wr_idx]),
    .i_fl_word (i_fl_rdata),
    .o_addr    (fmt_addr),
    .o_merged  (fmt_merged),
    .o_rdata   (fmt_rdata)
  );

  // Row moves the whole latch; word and page take a single command
  assign seq_count = (!erase_r && (op_r == pft_pkg::OP_ROW))
                     ? (IW+1)'(ROW_WORDS) : (IW+1)'(1);

  pft_op_seq #(.MAX_WORDS(ROW_WORDS)) u_seq (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_ce       (i_ce),
    .i_abort    (i_sys_rst),
    .i_start    (go),
    .i_count    (seq_count),
    .i_fl_done  (i_fl_done),
    .i_fl_err   (i_fl_err),
    .o_issue    (seq_issue),
    .o_idx      (seq_idx),
    .o_busy     (seq_busy),
    .o_fin      (seq_fin),
    .o_fail     (seq_fail)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write latch; no reset, contents are defined by table writes
  always_ff @(posedge i_core_clk) begin
    if (i_ce && wt_take) begin
      latch_mem[wr_idx] <= fmt_merged;
    end
  end

  // Target address follows the last table write
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_r <= '0;
    end else if (i_ce && wt_take) begin
      addr_r <= fmt_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table handshake: ack is a pulse, then one gap cycle so a request still
  // held during the ack is not taken twice
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tstate_r    <= T_IDLE;
      req_r       <= '0;
      o_tbl_ack   <= 1'b0;
      o_tbl_rdata <= 16'h0000;
    end else if (i_ce) begin
      o_tbl_ack <= 1'b0;
      case (tstate_r)
        T_IDLE: begin
          if (rd_take) begin
            tstate_r <= T_RD;
            req_r    <= i_tbl;
          end else if (wt_take) begin
            tstate_r  <= T_GAP;
            o_tbl_ack <= 1'b1;
          end
        end
        T_RD: begin
          // A failed read still answers so the core is never left waiting
          if (i_fl_done || i_fl_err) begin
            tstate_r    <= T_GAP;
            o_tbl_ack   <= 1'b1;
            o_tbl_rdata <= fmt_rdata;
          end
        end
        T_GAP: tstate_r <= T_IDLE;
        default: tstate_r <= T_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash macro command: strobes last one cycle
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fl_cmd <= '0;
    end else if (i_ce) begin
      o_fl_cmd.rd    <= 1'b0;
      o_fl_cmd.prog  <= 1'b0;
      o_fl_cmd.erase <= 1'b0;
      if (rd_take) begin
        o_fl_cmd.rd   <= 1'b1;
        o_fl_cmd.addr <= fmt_addr;
      end else if (seq_issue && erase_r) begin
        o_fl_cmd.erase <= 1'b1;
        o_fl_cmd.addr  <= {addr_r[pft_pkg::PC_W-1:pft_pkg::PAGE_LSB],
                           pft_pkg::PAGE_LSB'(0)};
      end else if (seq_issue && (op_r == pft_pkg::OP_ROW)) begin
        o_fl_cmd.prog <= 1'b1;
        o_fl_cmd.addr <= {addr_r[pft_pkg::PC_W-1:pft_pkg::ROW_LSB],
                          seq_idx, 1'b0};
        o_fl_cmd.data <= latch_mem[seq_idx];
      end else if (seq_issue) begin
        o_fl_cmd.prog <= 1'b1;
        o_fl_cmd.addr <= {addr_r[pft_pkg::PC_W-1:1], 1'b0};
        o_fl_cmd.data <= latch_mem[addr_r[IW:1]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register. Only power-on clears it; another reset leaves it,
  // except that an operation in flight is dropped and flagged.
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_r    <= pft_pkg::CTRL_RST[pft_pkg::BIT_WR];
      flash_write_enable_r  <= pft_pkg::CTRL_RST[pft_pkg::BIT_FLASH_WRITE_ENABLE];
      flash_write_error_r <= pft_pkg::CTRL_RST[pft_pkg::BIT_FLASH_WRITE_ERROR];
      erase_r <= pft_pkg::CTRL_RST[pft_pkg::BIT_ERASE];
      op_r    <= pft_pkg::CTRL_RST[pft_pkg::OP_LSB +: pft_pkg::OP_W];
    end else if (i_ce) begin
      if (ctrl_wr && !wr_r && !seq_busy && !i_sys_rst) begin
        flash_write_enable_r  <= i_sfr.wdata[pft_pkg::BIT_FLASH_WRITE_ENABLE];
        erase_r <= i_sfr.wdata[pft_pkg::BIT_ERASE];
        op_r    <= i_sfr.wdata[pft_pkg::OP_LSB +: pft_pkg::OP_W];
        if (!i_sfr.wdata[pft_pkg::BIT_FLASH_WRITE_ERROR]) begin
          flash_write_error_r <= 1'b0;
        end
      end
      if (go) begin
        wr_r <= 1'b1;
      end else if (seq_fin) begin
        wr_r <= 1'b0;
      end
      // Error set wins over a software clear in the same cycle
      if (abort || seq_fail || (start_req && !op_ok)) begin
        wr_r    <= 1'b0;
        flash_write_error_r <= 1'b1;
      end
    end
  end

  // Key: 55 then AA arms one start; any other control write disarms
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      key_r    <= pft_pkg::KEY_RST;
      unlock_r <= 2'd0;
    end else if (i_ce) begin
      if (i_sys_rst || ctrl_wr) begin
        unlock_r <= 2'd0;
      end else if (key_wr) begin
        key_r <= i_sfr.wdata[7:0];
        if (i_sfr.wdata[7:0] == pft_pkg::KEY1) begin
          unlock_r <= 2'd1;
        end else if ((i_sfr.wdata[7:0] == pft_pkg::KEY2)
                     && (unlock_r == 2'd1)) begin
          unlock_r <= 2'd2;
        end else begin
          unlock_r <= 2'd0;
        end
      end
    end
  end

  // Read port; unmapped addresses answer zero
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sfr_rdata <= 16'h0000;
      o_busy      <= 1'b0;
    end else if (i_ce) begin
      o_busy <= seq_busy;
      if (i_sfr.rd) begin
        case (i_sfr.addr)
          pft_pkg::ADDR_CTRL: o_sfr_rdata <= ctrl_val;
          pft_pkg::ADDR_KEY:  o_sfr_rdata <= {8'h00, key_r};
          default:            o_sfr_rdata <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  property p_start_flash_write_enable;
    $rose(wr_r) |-> $past(flash_write_enable_r) && $past(unlock_r) == 2'd2;
  endproperty
  a_start_flash_write_enable: assert property (p_start_flash_write_enable)
    else $error("start without enable or key");

  property p_no_flash_write_enable;
    i_ce && ctrl_wr && !flash_write_enable_r && !wr_r |=> !wr_r;
  endproperty
  a_no_flash_write_enable: assert property (p_no_flash_write_enable)
    else $error("start taken with enable clear");

  property p_abort;
    i_ce && abort |=> flash_write_error_r && !wr_r ##1 !seq_busy;
  endproperty
  a_abort: assert property (p_abort)
    else $error("reset during operation not flagged");

  property p_page;
    o_fl_cmd.erase |-> o_fl_cmd.addr[pft_pkg::PAGE_LSB-1:0] == '0
                       && erase_r && wr_r;
  endproperty
  a_page: assert property (p_page)
    else $error("erase address not page aligned");

  property p_row;
    o_fl_cmd.prog && op_r == pft_pkg::OP_ROW |->
      o_fl_cmd.addr[pft_pkg::PC_W-1:pft_pkg::ROW_LSB]
      == addr_r[pft_pkg::PC_W-1:pft_pkg::ROW_LSB];
  endproperty
  a_row: assert property (p_row)
    else $error("row program left its row");

  property p_rd_addr;
    i_ce && rd_take |=> o_fl_cmd.rd
      && o_fl_cmd.addr == {$past(i_table_page_reg), $past(i_tbl.ea)};
  endproperty
  a_rd_addr: assert property (p_rd_addr)
    else $error("read address not page joined to ea");

  property p_low;
    i_ce && tstate_r == T_RD && i_fl_done && !req_r.high
      && !req_r.byte_mode |=> o_tbl_ack
      && o_tbl_rdata == $past(i_fl_rdata[15:0]);
  endproperty
  a_low: assert property (p_low)
    else $error("low word read lane wrong");

  property p_high;
    i_ce && tstate_r == T_RD && i_fl_done && req_r.high
      && !req_r.byte_mode |=> o_tbl_rdata
      == {8'h00, $past(i_fl_rdata[23:16])};
  endproperty
  a_high: assert property (p_high)
    else $error("high word read lane wrong");

  property p_busy_blocks;
    o_fl_cmd.rd |-> !seq_busy && tstate_r == T_RD;
  endproperty
  a_busy_blocks: assert property (p_busy_blocks)
    else $error("table access during operation");

  c_row:  cover property (go && op_r == pft_pkg::OP_ROW);
  c_page: cover property (go && erase_r);
  c_word: cover property (seq_fin && op_r == pft_pkg::OP_WORD);
  c_read: cover property (tstate_r == T_RD ##1 o_tbl_ack);

endmodule

// ===== dv/pft_flash_model.sv
// Stand-in for the flash array: answers each command after a delay.
// Assumes one command outstanding and the access path's own clock.
`timescale 1ns/1ps
module pft_flash_model (
  input  wire logic                 i_core_clk, // Core clock
  input  wire logic                 i_nrst,     // Reset, low
  input  wire pft_pkg::pft_fl_cmd_s i_cmd,      // Command
  input  wire logic [3:0]           i_lat,      // Extra answer delay
  input  wire logic                 i_fail,     // Answer with a fault
  output logic                      o_done,     // Done pulse
  output logic                      o_err,      // Fault pulse
  output logic      [23:0]          o_rdata,    // Read word
  output int                        o_progs,    // Program commands seen
  output int                        o_erases    // Erase commands seen
);
  logic [4:0] wait_r;
  logic       issue;
  assign issue = i_cmd.rd | i_cmd.prog | i_cmd.erase;
  // Data lines toggle when idle so a stale word is never mistaken
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_r   <= 5'h00;
      o_done   <= 1'b0;
      o_err    <= 1'b0;
      o_rdata  <= 24'h000000;
      o_progs  <= 0;
      o_erases <= 0;
    end else begin
      o_done  <= 1'b0;
      o_err   <= 1'b0;
      o_rdata <= ~o_rdata;
      if (wait_r == 5'h01) begin
        o_done  <= !i_fail;
        o_err   <= i_fail;
        o_rdata <= {i_cmd.addr[23:1], 1'b0} ^ 24'h5A3C96;
      end
      if (issue) begin
        wait_r   <= {1'b0, i_lat} + 5'h01;
        o_progs  <= o_progs + int'(i_cmd.prog);
        o_erases <= o_erases + int'(i_cmd.erase);
      end else if (wait_r != 5'h00) begin
        wait_r <= wait_r - 5'h01;
      end
    end
  end
endmodule

// ===== dv/program_flash_table_access_tb.sv
// Self-checking bench for the flash table access path.
// Assumes the flash stand-in shares the core clock.
`timescale 1ns/1ps
module program_flash_table_access_tb;
  typedef struct packed {
    logic [7:0]  pg;
    logic [15:0] ea;
    logic        hi;
    logic        by;
    logic [15:0] ex;
  } pft_row_s;
  logic                  clk, nrst, sys_rst, ack, busy, done, err, fail, ce;
  logic [7:0]            page;
  logic [15:0]           trd, srd, d;
  logic [23:0]           frd;
  logic [3:0]            lat;
  pft_pkg::pft_tbl_req_s tbl;
  pft_pkg::pft_sfr_req_s sfr;
  pft_pkg::pft_fl_cmd_s  cmd;
  int                    fail_count, checks_done, progs, erases, p0;
  pft_row_s rows [7] = '{
    '{8'h12, 16'h0340, 1'b0, 1'b0, 16'h3FD6},
    '{8'h12, 16'h0341, 1'b0, 1'b1, 16'h003F},
    '{8'h12, 16'h0340, 1'b0, 1'b1, 16'h00D6},
    '{8'h12, 16'h0340, 1'b1, 1'b0, 16'h0048},
    '{8'h12, 16'h0341, 1'b1, 1'b1, 16'h0000},
    '{8'hFF, 16'hFFFE, 1'b0, 1'b0, 16'hC368},
    '{8'h00, 16'h0002, 1'b1, 1'b0, 16'h005A}};

  pft_table_access dut_u (
    .i_core_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_sys_rst(sys_rst),
    .i_table_page_reg(page), .i_tbl(tbl), .i_sfr(sfr),
    .i_fl_done(done), .i_fl_err(err), .i_fl_rdata(frd),
    .o_tbl_ack(ack), .o_tbl_rdata(trd), .o_sfr_rdata(srd),
    .o_fl_cmd(cmd), .o_busy(busy));
  pft_flash_model flash_u (
    .i_core_clk(clk), .i_nrst(nrst), .i_cmd(cmd), .i_lat(lat),
    .i_fail(fail), .o_done(done), .o_err(err), .o_rdata(frd),
    .o_progs(progs), .o_erases(erases));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A wait that runs out ends the run as a mismatch
  task automatic hang;
    cmp(24'h000001, 24'h000000);
    tally_and_finish();
  endtask

  // One-cycle register strobe; read data lands one edge later
  task automatic sfr_acc(input logic w, input logic [15:0] a, v);
    @(posedge clk);
    sfr <= '{wr: w, rd: !w, addr: a, wdata: v};
    @(posedge clk);
    sfr <= '0;
    #1 d = srd;
  endtask

  task automatic chk(input logic [15:0] a, input logic [15:0] exp);
    sfr_acc(1'b0, a, 16'h0000);
    cmp({8'h00, d}, {8'h00, exp});
  endtask

  // Request held until ack; dropped at the edge closing the ack cycle
  task automatic tbl_acc(input logic w, h, b, input logic [15:0] ea, v);
    @(posedge clk);
    tbl <= '{valid: 1'b1, write: w, high: h, byte_mode: b, ea: ea, wdata: v};
    repeat (200) begin
      @(posedge clk) #1;
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) hang();
    d = trd;
    @(posedge clk);
    tbl <= '0;
  endtask

  task automatic wait_idle;
    repeat (8) @(posedge clk);
    repeat (3000) begin
      @(posedge clk) #1;
      if (busy === 1'b0) break;
    end
    if (busy !== 1'b0) hang();
  endtask

  // Control write, unlock pair, then the start write
  task automatic run_op(input logic [15:0] c, input logic w);
    p0 = progs;
    sfr_acc(1'b1, pft_pkg::ADDR_CTRL, c);
    sfr_acc(1'b1, pft_pkg::ADDR_KEY, {8'h00, pft_pkg::KEY1});
    sfr_acc(1'b1, pft_pkg::ADDR_KEY, {8'h00, pft_pkg::KEY2});
    sfr_acc(1'b1, pft_pkg::ADDR_CTRL, c | 16'h8000);
    if (w) wait_idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst = 1'b0;
    sys_rst = 1'b0;
    ce = 1'b1;
    fail = 1'b0;
    lat = 4'h0;
    page = 8'h00;
    tbl = '0;
    sfr = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    chk(pft_pkg::ADDR_CTRL, pft_pkg::CTRL_RST);
    chk(pft_pkg::ADDR_KEY, 16'h0000);
    chk(16'h0762, 16'h0000);
    sfr_acc(1'b1, pft_pkg::ADDR_KEY, 16'h1255);
    chk(pft_pkg::ADDR_KEY, 16'h0055);
    $display("register test done");
    // Reads alternate prompt and slow flash answers
    foreach (rows[i]) begin
      @(posedge clk);
      lat <= i[0] ? 4'h5 : 4'h0;
      page <= rows[i].pg;
      tbl_acc(1'b0, rows[i].hi, rows[i].by, rows[i].ea, 16'h0000);
      cmp({8'h00, d}, {8'h00, rows[i].ex});
      if (!rows[i].ea[0]) cmp(cmd.addr, {rows[i].pg, rows[i].ea});
    end
    $display("table read test done");
    page <= 8'h12;
    tbl_acc(1'b1, 1'b0, 1'b0, 16'h0340, 16'hBEEF);
    run_op(16'h4003, 1'b1);
    cmp(24'(progs - p0), 24'h000001);
    cmp(cmd.addr, 24'h120340);
    cmp({8'h00, cmd.data[15:0]}, 24'h00BEEF);
    chk(pft_pkg::ADDR_CTRL, 16'h4003);
    run_op(16'h4001, 1'b1);
    cmp(24'(progs - p0), 24'h000040);
    run_op(16'h4042, 1'b1);
    cmp(24'(erases), 24'h000001);
    cmp({14'h0000, cmd.addr[9:0]}, 24'h000000);
    $display("program and erase test done");
    run_op(16'h0001, 1'b1);
    cmp(24'(progs - p0), 24'h000000);
    chk(pft_pkg::ADDR_CTRL, 16'h0001);
    run_op(16'h4005, 1'b1);
    chk(pft_pkg::ADDR_CTRL, 16'h6005);
    fail <= 1'b1;
    run_op(16'h4003, 1'b1);
    chk(pft_pkg::ADDR_CTRL, 16'h6003);
    fail <= 1'b0;
    // Clock enable low: a key write must leave the register untouched
    ce <= 1'b0;
    sfr_acc(1'b1, pft_pkg::ADDR_KEY, 16'h0012);
    ce <= 1'b1;
    chk(pft_pkg::ADDR_KEY, 16'h00AA);
    $display("refusal test done");
    // Non-power-on reset in mid-row, then power-on reset
    run_op(16'h4001, 1'b0);
    repeat (30) @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(pft_pkg::ADDR_CTRL, 16'h6001);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    chk(pft_pkg::ADDR_CTRL, 16'h0000);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
